// >>> include/mon_regs_pkg.sv
// Register map, field layout and constants for the monitor result and limit bank
// Overview of operation
// - Shunt result holds averaged value, not raw
// - Bit 15 is sign, twos complement
// - Shunt magnitude bits 14-3, 40 uV per count
// - Bus magnitude bits 14-3, 8 mV per count
// - Results read-only, low three bits zero
// - Channel 2/3 results at 03h-06h, reset zero
// - Critical limit checked on every raw channel-1 shunt conversion
// - Limit register 07h, read/write, resets 7FF8h
// - Averaging count 1 to 1024 by select
package mon_regs_pkg;
    localparam int          DATA_W          = 16;
    localparam int          ADDR_W          = 8;
    localparam int          MAG_W           = 12;
    localparam int          SEL_W           = 3;
    localparam int          CHAN_W          = 2;
    localparam int          ACC_W           = MAG_W + 1 + 10;
    localparam int          SIGN_BIT        = 15;
    localparam int          MAG_LSB         = 3;
    localparam int          SHIFT_W         = 4;

    localparam logic [7:0]  ADDR_CH1_BUS    = 8'h02;
    localparam logic [7:0]  ADDR_CH2_SHUNT  = 8'h03;
    localparam logic [7:0]  ADDR_CH2_BUS    = 8'h04;
    localparam logic [7:0]  ADDR_CH3_SHUNT  = 8'h05;
    localparam logic [7:0]  ADDR_CH3_BUS    = 8'h06;
    localparam logic [7:0]  ADDR_CH1_LIMIT  = 8'h07;

    localparam logic [15:0] RESULT_RESET    = 16'h0000;
    localparam logic [15:0] LIMIT_RESET     = 16'h7FF8;
    localparam logic [15:0] RESERVED_MASK   = 16'hFFF8;
    localparam logic [15:0] UNMAPPED_VALUE  = 16'h0000;

    localparam logic [1:0]  CHAN_1          = 2'h1;
    localparam logic [1:0]  CHAN_2          = 2'h2;
    localparam logic [1:0]  CHAN_3          = 2'h3;

    typedef enum logic {MEAS_SHUNT, MEAS_BUS} meas_kind_t;
endpackage

// >>> design/sample_averager.sv
// Sign-aware sample accumulator producing one averaged 13-bit result
`timescale 1ns/100ps
`default_nettype none
module sample_averager
    import mon_regs_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    input  wire logic                        clear,
    input  wire logic [mon_regs_pkg::SEL_W-1:0] sampleCountSelect,
    input  wire logic                        sampleValid,
    input  wire logic [mon_regs_pkg::MAG_W:0] sampleValue,
    output logic                             avgValid,
    output logic      [mon_regs_pkg::MAG_W:0] avgValue
);
    // Log2 of sample count: 1,4,16,64,128,256,512,1024
    function automatic logic [SHIFT_W-1:0] countShift(input logic [SEL_W-1:0] sel);
        logic [SHIFT_W-1:0] s;
        s = 4'h0;
        unique case (sel)
            3'h0: s = 4'h0;
            3'h1: s = 4'h2;
            3'h2: s = 4'h4;
            3'h3: s = 4'h6;
            3'h4: s = 4'h7;
            3'h5: s = 4'h8;
            3'h6: s = 4'h9;
            3'h7: s = 4'hA;
        endcase
        return s;
    endfunction

    logic signed [ACC_W-1:0] accQ;
    logic        [10:0]      cntQ;
    wire  [SHIFT_W-1:0]      shiftAmt = countShift(sampleCountSelect);
    wire  [10:0]             target   = 11'(11'h001 << shiftAmt);
    wire  signed [ACC_W-1:0] accNext  = accQ + ACC_W'(signed'(sampleValue));
    wire                     lastOne  = sampleValid && (cntQ + 11'h001 == target);
    wire  signed [ACC_W-1:0] quotient = accNext >>> shiftAmt;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            accQ     <= '0;
            cntQ     <= '0;
            avgValid <= 1'b0;
            avgValue <= '0;
        end else begin
            avgValid <= 1'b0;
            if (clear) begin
                accQ <= '0;
                cntQ <= '0;
            end else if (lastOne) begin
                accQ     <= '0;
                cntQ     <= '0;
                avgValid <= 1'b1;
                avgValue <= quotient[MAG_W:0];
            end else if (sampleValid) begin
                accQ <= accNext;
                cntQ <= cntQ + 11'h001;
            end
        end
    end
endmodule
`default_nettype wire

// >>> design/monitor_result_and_limit_regs.sv
// Result and channel-1 critical limit register bank with conversion averaging
`timescale 1ns/100ps
`default_nettype none
module monitor_result_and_limit_regs
    import mon_regs_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    input  wire logic                          softReset,
    input  wire logic [mon_regs_pkg::SEL_W-1:0] sampleCountSelect,
    input  wire logic                          convValid,
    input  wire logic [mon_regs_pkg::CHAN_W-1:0] convChannel,
    input  wire logic                          convIsBus,
    input  wire logic [mon_regs_pkg::MAG_W:0]  convValue,
    input  wire logic [mon_regs_pkg::ADDR_W-1:0] regAddr,
    input  wire logic                          regWrite,
    input  wire logic [mon_regs_pkg::DATA_W-1:0] regWriteData,
    output logic      [mon_regs_pkg::DATA_W-1:0] regReadData,
    output logic                               ch1Critical
);
    // Convert signed 13-bit conversion to register word, low bits zero
    function automatic logic [DATA_W-1:0] toWord(input logic [MAG_W:0] v);
        return {v, 3'b000};
    endfunction

    // Strobe decode shared by every channel and measurement kind
    function automatic logic convMatch(input logic              valid,
                                       input logic [CHAN_W-1:0] ch,
                                       input logic              bus,
                                       input logic [CHAN_W-1:0] wantCh,
                                       input logic              wantBus);
        return valid && ch == wantCh && bus == wantBus;
    endfunction

    logic [DATA_W-1:0] ch1BusQ;
    logic [DATA_W-1:0] ch2ShuntQ;
    logic [DATA_W-1:0] ch2BusQ;
    logic [DATA_W-1:0] ch3ShuntQ;
    logic [DATA_W-1:0] ch3BusQ;
    logic [DATA_W-1:0] ch1LimitQ;
    logic              ch1CriticalQ;

    // One averager per stored result; channel 1 shunt register lives elsewhere
    // but its raw samples still feed the critical compare.
    wire selCh1Bus   = convMatch(convValid, convChannel, convIsBus, CHAN_1, MEAS_BUS);
    wire selCh2Shunt = convMatch(convValid, convChannel, convIsBus, CHAN_2, MEAS_SHUNT);
    wire selCh2Bus   = convMatch(convValid, convChannel, convIsBus, CHAN_2, MEAS_BUS);
    wire selCh3Shunt = convMatch(convValid, convChannel, convIsBus, CHAN_3, MEAS_SHUNT);
    wire selCh3Bus   = convMatch(convValid, convChannel, convIsBus, CHAN_3, MEAS_BUS);
    wire ch1ShuntRaw = convMatch(convValid, convChannel, convIsBus, CHAN_1, MEAS_SHUNT);

    wire                avgV1B;
    wire                avgV2S;
    wire                avgV2B;
    wire                avgV3S;
    wire                avgV3B;
    wire [MAG_W:0]      avgD1B;
    wire [MAG_W:0]      avgD2S;
    wire [MAG_W:0]      avgD2B;
    wire [MAG_W:0]      avgD3S;
    wire [MAG_W:0]      avgD3B;

    sample_averager uAvg1B (
        .clk               (clk),
        .reset_n           (reset_n),
        .clear             (softReset),
        .sampleCountSelect (sampleCountSelect),
        .sampleValid       (selCh1Bus),
        .sampleValue       (convValue),
        .avgValid          (avgV1B),
        .avgValue          (avgD1B)
    );
    sample_averager uAvg2S (
        .clk               (clk),
        .reset_n           (reset_n),
        .clear             (softReset),
        .sampleCountSelect (sampleCountSelect),
        .sampleValid       (selCh2Shunt),
        .sampleValue       (convValue),
        .avgValid          (avgV2S),
        .avgValue          (avgD2S)
    );
    sample_averager uAvg2B (
        .clk               (clk),
        .reset_n           (reset_n),
        .clear             (softReset),
        .sampleCountSelect (sampleCountSelect),
        .sampleValid       (selCh2Bus),
        .sampleValue       (convValue),
        .avgValid          (avgV2B),
        .avgValue          (avgD2B)
    );
    sample_averager uAvg3S (
        .clk               (clk),
        .reset_n           (reset_n),
        .clear             (softReset),
        .sampleCountSelect (sampleCountSelect),
        .sampleValid       (selCh3Shunt),
        .sampleValue       (convValue),
        .avgValid          (avgV3S),
        .avgValue          (avgD3S)
    );
    sample_averager uAvg3B (
        .clk               (clk),
        .reset_n           (reset_n),
        .clear             (softReset),
        .sampleCountSelect (sampleCountSelect),
        .sampleValid       (selCh3Bus),
        .sampleValue       (convValue),
        .avgValid          (avgV3B),
        .avgValue          (avgD3B)
    );

    // Compare raw conversion, signed, against the limit field
    wire signed [MAG_W:0] limitField = ch1LimitQ[DATA_W-1:MAG_LSB];
    wire signed [MAG_W:0] rawSigned  = convValue;
    wire                  overLimit  = ch1ShuntRaw && (rawSigned > limitField);
    wire                  limitWrite = regWrite && regAddr == ADDR_CH1_LIMIT;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ch1BusQ <= RESULT_RESET;
        end else if (softReset) begin
            ch1BusQ <= RESULT_RESET;
        end else if (avgV1B) begin
            ch1BusQ <= toWord(avgD1B);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ch2ShuntQ <= RESULT_RESET;
        end else if (softReset) begin
            ch2ShuntQ <= RESULT_RESET;
        end else if (avgV2S) begin
            ch2ShuntQ <= toWord(avgD2S);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ch2BusQ <= RESULT_RESET;
        end else if (softReset) begin
            ch2BusQ <= RESULT_RESET;
        end else if (avgV2B) begin
            ch2BusQ <= toWord(avgD2B);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ch3ShuntQ <= RESULT_RESET;
        end else if (softReset) begin
            ch3ShuntQ <= RESULT_RESET;
        end else if (avgV3S) begin
            ch3ShuntQ <= toWord(avgD3S);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ch3BusQ <= RESULT_RESET;
        end else if (softReset) begin
            ch3BusQ <= RESULT_RESET;
        end else if (avgV3B) begin
            ch3BusQ <= toWord(avgD3B);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ch1LimitQ <= LIMIT_RESET;
        end else if (softReset) begin
            ch1LimitQ <= LIMIT_RESET;
        end else if (limitWrite) begin
            // Reserved bits are masked to zero on write so the compare stays aligned
            ch1LimitQ <= regWriteData & RESERVED_MASK;
        end
    end

    // Flag is a level that follows the latest channel-1 shunt conversion
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ch1CriticalQ <= 1'b0;
        end else if (softReset) begin
            ch1CriticalQ <= 1'b0;
        end else if (ch1ShuntRaw) begin
            ch1CriticalQ <= overLimit;
        end
    end
    assign ch1Critical = ch1CriticalQ;

    // Result registers ignore writes; read data is registered from the address
    logic [DATA_W-1:0] readMux;
    always_comb begin
        readMux = UNMAPPED_VALUE;
        unique case (regAddr)
            ADDR_CH1_BUS:   readMux = ch1BusQ;
            ADDR_CH2_SHUNT: readMux = ch2ShuntQ;
            ADDR_CH2_BUS:   readMux = ch2BusQ;
            ADDR_CH3_SHUNT: readMux = ch3ShuntQ;
            ADDR_CH3_BUS:   readMux = ch3BusQ;
            ADDR_CH1_LIMIT: readMux = ch1LimitQ;
            default:        readMux = UNMAPPED_VALUE;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            regReadData <= '0;
        end else begin
            regReadData <= readMux & RESERVED_MASK;
        end
    end

    a_read_low_zero: assert property (@(posedge clk) disable iff (!reset_n)
        regReadData[MAG_LSB-1:0] == 3'b000) else $error("low bits not zero");
    a_result_readonly: assert property (@(posedge clk) disable iff (!reset_n)
        (regWrite && regAddr == ADDR_CH2_SHUNT && !avgV2S && !softReset)
        |=> ch2ShuntQ == $past(ch2ShuntQ)) else $error("result written");
    a_limit_write: assert property (@(posedge clk) disable iff (!reset_n)
        (limitWrite && !softReset) |=> ch1LimitQ == ($past(regWriteData) & RESERVED_MASK))
        else $error("limit not stored");
    a_soft_reset: assert property (@(posedge clk) disable iff (!reset_n)
        softReset |=> ch1LimitQ == LIMIT_RESET && ch2BusQ == RESULT_RESET && !ch1Critical)
        else $error("soft reset defaults");
    a_crit_raise: assert property (@(posedge clk) disable iff (!reset_n)
        (ch1ShuntRaw && !softReset && $signed(convValue) > $signed(ch1LimitQ[15:3]))
        |=> ch1Critical) else $error("critical missed");
    a_crit_clear: assert property (@(posedge clk) disable iff (!reset_n)
        (ch1ShuntRaw && !softReset && $signed(convValue) <= $signed(ch1LimitQ[15:3]))
        |=> !ch1Critical) else $error("critical false");
    a_avg_format: assert property (@(posedge clk) disable iff (!reset_n)
        (avgV3S && !softReset) |=> ch3ShuntQ == {$past(avgD3S), 3'b000})
        else $error("shunt format");
    a_addr_decode: assert property (@(posedge clk) disable iff (!reset_n)
        (regAddr == ADDR_CH3_BUS) |=> regReadData == ($past(ch3BusQ) & RESERVED_MASK))
        else $error("decode 06h");
    a_single_raw: assert property (@(posedge clk) disable iff (!reset_n)
        (sampleCountSelect == 3'h0 && selCh2Bus && !softReset) |=> avgV2B)
        else $error("one-sample average");
    a_sign_bit: assert property (@(posedge clk) disable iff (!reset_n)
        (avgV2B && !softReset) |=> ch2BusQ[SIGN_BIT] == $past(avgD2B[MAG_W]))
        else $error("sign bit");

    // Read port decode, one property per address
    a_decode_ch1_bus: assert property (@(posedge clk) disable iff (!reset_n)
        (regAddr == ADDR_CH1_BUS) |=> regReadData == ($past(ch1BusQ) & RESERVED_MASK))
        else $error("decode 02h");
    a_decode_ch2_shunt: assert property (@(posedge clk) disable iff (!reset_n)
        (regAddr == ADDR_CH2_SHUNT) |=> regReadData == ($past(ch2ShuntQ) & RESERVED_MASK))
        else $error("decode 03h");
    a_decode_ch2_bus: assert property (@(posedge clk) disable iff (!reset_n)
        (regAddr == ADDR_CH2_BUS) |=> regReadData == ($past(ch2BusQ) & RESERVED_MASK))
        else $error("decode 04h");
    a_decode_ch3_shunt: assert property (@(posedge clk) disable iff (!reset_n)
        (regAddr == ADDR_CH3_SHUNT) |=> regReadData == ($past(ch3ShuntQ) & RESERVED_MASK))
        else $error("decode 05h");
    a_decode_limit: assert property (@(posedge clk) disable iff (!reset_n)
        (regAddr == ADDR_CH1_LIMIT) |=> regReadData == ($past(ch1LimitQ) & RESERVED_MASK))
        else $error("decode 07h");
    a_decode_unmapped: assert property (@(posedge clk) disable iff (!reset_n)
        (regAddr < ADDR_CH1_BUS || regAddr > ADDR_CH1_LIMIT) |=> regReadData == UNMAPPED_VALUE)
        else $error("unmapped read");

    // Result registers ignore the register port
    a_readonly_ch1_bus: assert property (@(posedge clk) disable iff (!reset_n)
        (regWrite && regAddr == ADDR_CH1_BUS && !avgV1B && !softReset)
        |=> ch1BusQ == $past(ch1BusQ)) else $error("result 02h written");
    a_readonly_ch2_bus: assert property (@(posedge clk) disable iff (!reset_n)
        (regWrite && regAddr == ADDR_CH2_BUS && !avgV2B && !softReset)
        |=> ch2BusQ == $past(ch2BusQ)) else $error("result 04h written");
    a_readonly_ch3_shunt: assert property (@(posedge clk) disable iff (!reset_n)
        (regWrite && regAddr == ADDR_CH3_SHUNT && !avgV3S && !softReset)
        |=> ch3ShuntQ == $past(ch3ShuntQ)) else $error("result 05h written");
    a_readonly_ch3_bus: assert property (@(posedge clk) disable iff (!reset_n)
        (regWrite && regAddr == ADDR_CH3_BUS && !avgV3B && !softReset)
        |=> ch3BusQ == $past(ch3BusQ)) else $error("result 06h written");

    // Averaged word lands above the reserved bits
    a_format_ch1_bus: assert property (@(posedge clk) disable iff (!reset_n)
        (avgV1B && !softReset) |=> ch1BusQ == {$past(avgD1B), 3'b000})
        else $error("bus format 02h");
    a_format_ch2_shunt: assert property (@(posedge clk) disable iff (!reset_n)
        (avgV2S && !softReset) |=> ch2ShuntQ == {$past(avgD2S), 3'b000})
        else $error("shunt format 03h");
    a_format_ch2_bus: assert property (@(posedge clk) disable iff (!reset_n)
        (avgV2B && !softReset) |=> ch2BusQ == {$past(avgD2B), 3'b000})
        else $error("bus format 04h");
    a_format_ch3_bus: assert property (@(posedge clk) disable iff (!reset_n)
        (avgV3B && !softReset) |=> ch3BusQ == {$past(avgD3B), 3'b000})
        else $error("bus format 06h");

    // State moves only on its own event
    a_crit_hold: assert property (@(posedge clk) disable iff (!reset_n)
        (!ch1ShuntRaw && !softReset) |=> $stable(ch1Critical))
        else $error("critical changed");
    a_limit_hold: assert property (@(posedge clk) disable iff (!reset_n)
        (!limitWrite && !softReset) |=> $stable(ch1LimitQ))
        else $error("limit changed");
    a_hold_ch2_shunt: assert property (@(posedge clk) disable iff (!reset_n)
        (!avgV2S && !softReset) |=> $stable(ch2ShuntQ))
        else $error("shunt 03h changed");
    a_hold_ch3_shunt: assert property (@(posedge clk) disable iff (!reset_n)
        (!avgV3S && !softReset) |=> $stable(ch3ShuntQ))
        else $error("shunt 05h changed");
    a_soft_results: assert property (@(posedge clk) disable iff (!reset_n)
        softReset |=> ch1BusQ == RESULT_RESET && ch2ShuntQ == RESULT_RESET
            && ch3ShuntQ == RESULT_RESET && ch3BusQ == RESULT_RESET)
        else $error("results not cleared");
endmodule
`default_nettype wire

// >>> tb/conversion_source_model.sv
// Conversion source model feeding raw samples into the bank
`timescale 1ns/100ps
`default_nettype none
module conversion_source_model
(
    input  wire logic                            clk,
    input  wire logic                            reset_n,
    input  wire logic                            send,
    input  wire logic [mon_regs_pkg::CHAN_W-1:0] sendChannel,
    input  wire logic                            sendIsBus,
    input  wire logic [mon_regs_pkg::MAG_W:0]    sendValue,
    output logic                                 convValid,
    output logic      [mon_regs_pkg::CHAN_W-1:0] convChannel,
    output logic                                 convIsBus,
    output logic      [mon_regs_pkg::MAG_W:0]    convValue
);
    import mon_regs_pkg::*;
    // Idle fields toggle each cycle so a late capture shows up as a wrong value
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            convValid   <= 1'b0;
            convChannel <= '0;
            convIsBus   <= 1'b0;
            convValue   <= '0;
        end else begin
            convValid   <= send;
            convChannel <= send ? sendChannel : ~convChannel;
            convIsBus   <= send ? sendIsBus : ~convIsBus;
            convValue   <= send ? sendValue : ~convValue;
        end
    end
endmodule
`default_nettype wire

// >>> tb/monitor_result_and_limit_regs_tb.sv
// Testbench for the result and limit register bank
`timescale 1ns/100ps
`default_nettype none
module monitor_result_and_limit_regs_tb;
    import mon_regs_pkg::*;
    logic        clk, reset_n, softReset, send, sendIsBus, regWrite;
    logic        convValid, convIsBus, ch1Critical;
    logic [2:0]  sel;
    logic [1:0]  sendChannel, convChannel;
    logic [12:0] sendValue, convValue;
    logic [7:0]  regAddr;
    logic [15:0] regWriteData, regReadData;
    int          err_total, compares, cycles;
    conversion_source_model conversion_source_model_i (.clk(clk), .reset_n(reset_n),
        .send(send), .sendChannel(sendChannel), .sendIsBus(sendIsBus), .sendValue(sendValue),
        .convValid(convValid), .convChannel(convChannel), .convIsBus(convIsBus),
        .convValue(convValue));
    monitor_result_and_limit_regs monitor_result_and_limit_regs_i (.clk(clk),
        .reset_n(reset_n), .softReset(softReset), .sampleCountSelect(sel),
        .convValid(convValid), .convChannel(convChannel), .convIsBus(convIsBus),
        .convValue(convValue), .regAddr(regAddr), .regWrite(regWrite),
        .regWriteData(regWriteData), .regReadData(regReadData), .ch1Critical(ch1Critical));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic finish_test();
        $display("Mismatches %0d, comparisons %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        regAddr <= a;
        repeat (3) @(posedge clk);
        #1 chk(regReadData, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        regAddr <= a;
        regWrite <= 1'b1;
        regWriteData <= d;
        @(posedge clk);
        regWrite <= 1'b0;
        @(posedge clk);
    endtask
    task automatic conv(input logic [1:0] ch, input logic bus, input logic [12:0] v);
        send <= 1'b1;
        sendChannel <= ch;
        sendIsBus <= bus;
        sendValue <= v;
        @(posedge clk);
        send <= 1'b0;
        @(posedge clk);
    endtask
    task automatic crit(input logic exp);
        @(posedge clk);
        #1 chk({15'h0000, ch1Critical}, {15'h0000, exp});
    endtask
    task automatic restart(input logic [2:0] s);
        sel <= s;
        softReset <= 1'b1;
        @(posedge clk);
        softReset <= 1'b0;
        @(posedge clk);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 12000) begin
            err_total++;
            finish_test();
        end
    end
    initial begin
        int n;
        {softReset, send, sendIsBus, regWrite, sel, sendChannel} = '0;
        {sendValue, regAddr, regWriteData, err_total, compares, cycles} = '0;
        reset_n = 1'b0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        for (int a = 2; a <= 8; a++) rd(8'(a), a == 7 ? LIMIT_RESET : RESULT_RESET);
        wr(ADDR_CH1_LIMIT, 16'h1234);
        rd(ADDR_CH1_LIMIT, 16'h1230);
        // Sign, full scale and most negative codes land in bits 15:3
        for (int i = 0; i < 5; i++) conv(2'((i + 3) / 2), i % 2 == 0, 13'h0FFF - 13'(i * 700));
        for (int i = 2; i < 7; i++) wr(8'(i), 16'hFFFF);
        for (int i = 0; i < 5; i++) rd(8'(i + 2), {13'h0FFF - 13'(i * 700), 3'h0});
        conv(CHAN_3, 1'b0, 13'h1000);
        rd(ADDR_CH3_SHUNT, 16'h8000);
        for (int c = 0; c < 8; c++) begin
            n = c == 0 ? 1 : (c < 4 ? 1 << (2 * c) : 1 << (c + 3));
            restart(3'(c));
            for (int k = 1; k < n; k++) conv(CHAN_2, 1'b0, 13'h0064);
            rd(ADDR_CH2_SHUNT, RESULT_RESET);
            conv(CHAN_2, 1'b0, 13'h0064);
            rd(ADDR_CH2_SHUNT, 16'h0320);
        end
        restart(3'h1);
        conv(CHAN_3, 1'b1, 13'h1FFE);
        conv(CHAN_3, 1'b1, 13'h1FFF);
        conv(CHAN_3, 1'b1, 13'h1FFF);
        conv(CHAN_3, 1'b1, 13'h0001);
        rd(ADDR_CH3_BUS, 16'hFFF8);
        wr(ADDR_CH1_LIMIT, 16'h0100);
        conv(CHAN_1, 1'b0, 13'h0021);
        crit(1'b1);
        conv(CHAN_1, 1'b0, 13'h0020);
        crit(1'b0);
        conv(CHAN_2, 1'b0, 13'h0FFF);
        conv(CHAN_1, 1'b1, 13'h0FFF);
        conv(2'h0, 1'b0, 13'h0FFF);
        crit(1'b0);
        wr(ADDR_CH1_LIMIT, 16'hFFFF);
        rd(ADDR_CH1_LIMIT, 16'hFFF8);
        conv(CHAN_1, 1'b0, 13'h0000);
        crit(1'b1);
        conv(CHAN_1, 1'b0, 13'h1FFE);
        crit(1'b0);
        restart(3'h0);
        rd(ADDR_CH1_LIMIT, LIMIT_RESET);
        rd(ADDR_CH3_BUS, RESULT_RESET);
        finish_test();
    end
endmodule
`default_nettype wire
